/* scicfg_defs.vh */
// Address map, field positions and reset values of the config bank
`ifndef SCICFG_DEFS_VH
`define SCICFG_DEFS_VH

// Register addresses
`define SCICFG_ADDR_LVL        8'h08
`define SCICFG_ADDR_CTRL       8'h09
`define SCICFG_ADDR_MAKER_LO   8'h0C
`define SCICFG_ADDR_MAKER_HI   8'h0D
`define SCICFG_ADDR_PVA_LO     8'h10
`define SCICFG_ADDR_PVA_HI     8'h11
`define SCICFG_ADDR_PVB_LO     8'h12
`define SCICFG_ADDR_PVB_HI     8'h13
`define SCICFG_ADDR_OFB_LO     8'h14
`define SCICFG_ADDR_OFB_HI     8'h15
`define SCICFG_ADDR_LPW_LO     8'h16
`define SCICFG_ADDR_LPW_HI     8'h17
`define SCICFG_ADDR_SFB_LO     8'h1A
`define SCICFG_ADDR_SFB_HI     8'h1B
`define SCICFG_ADDR_MCA_LO     8'h30
`define SCICFG_ADDR_MCA_HI     8'h31
`define SCICFG_ADDR_MCB_LO     8'h32
`define SCICFG_ADDR_MCB_HI     8'h33

// Bit positions
`define SCICFG_BIT_SERIAL_LVL  0
`define SCICFG_BIT_IRQ_LVL     1
`define SCICFG_BIT_FBLOCK_LVL  2
`define SCICFG_BIT_COMMIT      0
`define SCICFG_BIT_RB_SEL      1

// Field widths
`define SCICFG_W_WIDE          15
`define SCICFG_W_SFB           9

// Reset values
`define SCICFG_RST_SERIAL_LVL  1'b0
`define SCICFG_RST_IRQ_LVL     1'b1
`define SCICFG_RST_FBLOCK_LVL  1'b0
`define SCICFG_RST_RB_SEL      1'b0
`define SCICFG_RST_PREDIV      15'h0008
`define SCICFG_RST_OFB         15'h0008
`define SCICFG_RST_LPW         15'h0003
`define SCICFG_RST_SFB         9'h000
`define SCICFG_RST_MON         15'h0000

// Arbitrary neutral maker code, not a real assignment
`define SCICFG_MAKER_CODE      16'h5A3C

`define SCICFG_BYTE_ZERO       8'h00

`endif

/* scicfg_dbuf.v */
// One double-buffered field: shadow copy, active copy, read-back select
`timescale 1ns/1ps
`include "scicfg_defs.vh"

module scicfg_dbuf #(
   parameter        W   = 15,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input  wire         clk_in,
   input  wire         rst_n_in,
   input  wire         wr_lo_in,
   input  wire         wr_hi_in,
   input  wire [7:0]   wdata_in,
   input  wire         commit_in,
   input  wire         rb_shadow_in,
   output wire [W-1:0] active_out,
   output wire [7:0]   rd_lo_out,
   output wire [7:0]   rd_hi_out
);

   reg  [W-1:0] shadow_q;
   reg  [W-1:0] active_q;
   wire [15:0]  shadow_wide;
   wire [15:0]  rd_wide;

   assign shadow_wide = {{(16-W){1'b0}}, shadow_q};

   // Host writes land in the shadow only
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         shadow_q <= RST;
      end else begin
         if (wr_lo_in)
            shadow_q <= {shadow_wide[W-1:8], wdata_in};
         if (wr_hi_in)
            shadow_q <= {wdata_in[W-9:0], shadow_q[7:0]};
      end
   end

   // Active copy moves only on commit, all fields in the same edge
   always @(posedge clk_in) begin
      if (!rst_n_in)
         active_q <= RST;
      else if (commit_in)
         active_q <= shadow_q;
   end

   // Unused upper bits read as zero
   assign rd_wide   = rb_shadow_in ? shadow_wide
                                   : {{(16-W){1'b0}}, active_q};
   assign rd_lo_out = rd_wide[7:0];
   assign rd_hi_out = rd_wide[15:8];
   assign active_out = active_q;

endmodule

/* scicfg_bank.v */
// Configuration bank: commit of divider shadows, level selects, maker code
`timescale 1ns/1ps
`include "scicfg_defs.vh"
// Notes on behaviour
// - Writing commit 1 copies shadows, self-clears
// - Every wide divider field has shadow and active
// - Read-only maker code at 0x0C low, 0x0D
// - Feedback lock pin level resets 0, 1.8V
// - Interrupt/oscillator lock level resets 1, 3.3V
// - Serial data pins level resets 0, 1.8V
// - Read-back select: 0 active, 1 shadow

module scicfg_bank (
   input  wire        CLK_SYS_IN,
   input  wire        RESETN_IN,
   input  wire        REG_WR_IN,
   input  wire        REG_RD_IN,
   input  wire [7:0]  REG_ADDR_IN,
   input  wire [7:0]  REG_WDATA_IN,
   output reg  [7:0]  REG_RDATA_OUT,
   output reg         REG_RVALID_OUT,
   output reg         COMMIT_PULSE_OUT,
   output reg         FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT,
   output reg         IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT,
   output reg         SERIAL_IO_LEVEL_SELECT_OUT,
   output wire [14:0] INPUT_PREDIV_A_OUT,
   output wire [14:0] INPUT_PREDIV_B_OUT,
   output wire [14:0] OSC_FEEDBACK_DIV_OUT,
   output wire [14:0] LOCK_PHASE_WINDOW_OUT,
   output wire [8:0]  SYNTH_FEEDBACK_DIV_OUT,
   output wire [14:0] MONITOR_COUNT_A_OUT,
   output wire [14:0] MONITOR_COUNT_B_OUT
);

   localparam NF = 7;

   reg          readback_copy_select_q;
   reg  [7:0]   rdata_d;
   wire [NF-1:0] wr_lo;
   wire [NF-1:0] wr_hi;
   wire [8*NF-1:0] rd_lo;
   wire [8*NF-1:0] rd_hi;
   wire         wr_lvl;
   wire         wr_ctrl;
   wire [15:0]  maker_code;

   // Fixed code; split into bytes by slicing, never by truncation
   assign maker_code = `SCICFG_MAKER_CODE;

   // Byte strobes per double-buffered field
   assign wr_lo[0] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_PVA_LO);
   assign wr_hi[0] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_PVA_HI);
   assign wr_lo[1] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_PVB_LO);
   assign wr_hi[1] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_PVB_HI);
   assign wr_lo[2] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_OFB_LO);
   assign wr_hi[2] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_OFB_HI);
   assign wr_lo[3] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_LPW_LO);
   assign wr_hi[3] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_LPW_HI);
   assign wr_lo[4] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_SFB_LO);
   assign wr_hi[4] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_SFB_HI);
   assign wr_lo[5] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_MCA_LO);
   assign wr_hi[5] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_MCA_HI);
   assign wr_lo[6] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_MCB_LO);
   assign wr_hi[6] = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_MCB_HI);
   assign wr_lvl   = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_LVL);
   assign wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_CTRL);

   // Double-buffered divider fields, all sharing one commit strobe
   scicfg_dbuf #(.W(`SCICFG_W_WIDE), .RST(`SCICFG_RST_PREDIV)) u_pva (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[0]),
      .wr_hi_in     (wr_hi[0]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (INPUT_PREDIV_A_OUT),
      .rd_lo_out    (rd_lo[7:0]),
      .rd_hi_out    (rd_hi[7:0])
   );
   scicfg_dbuf #(.W(`SCICFG_W_WIDE), .RST(`SCICFG_RST_PREDIV)) u_pvb (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[1]),
      .wr_hi_in     (wr_hi[1]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (INPUT_PREDIV_B_OUT),
      .rd_lo_out    (rd_lo[15:8]),
      .rd_hi_out    (rd_hi[15:8])
   );
   scicfg_dbuf #(.W(`SCICFG_W_WIDE), .RST(`SCICFG_RST_OFB)) u_ofb (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[2]),
      .wr_hi_in     (wr_hi[2]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (OSC_FEEDBACK_DIV_OUT),
      .rd_lo_out    (rd_lo[23:16]),
      .rd_hi_out    (rd_hi[23:16])
   );
   scicfg_dbuf #(.W(`SCICFG_W_WIDE), .RST(`SCICFG_RST_LPW)) u_lpw (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[3]),
      .wr_hi_in     (wr_hi[3]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (LOCK_PHASE_WINDOW_OUT),
      .rd_lo_out    (rd_lo[31:24]),
      .rd_hi_out    (rd_hi[31:24])
   );
   scicfg_dbuf #(.W(`SCICFG_W_SFB), .RST(`SCICFG_RST_SFB)) u_sfb (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[4]),
      .wr_hi_in     (wr_hi[4]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (SYNTH_FEEDBACK_DIV_OUT),
      .rd_lo_out    (rd_lo[39:32]),
      .rd_hi_out    (rd_hi[39:32])
   );
   scicfg_dbuf #(.W(`SCICFG_W_WIDE), .RST(`SCICFG_RST_MON)) u_mca (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[5]),
      .wr_hi_in     (wr_hi[5]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (MONITOR_COUNT_A_OUT),
      .rd_lo_out    (rd_lo[47:40]),
      .rd_hi_out    (rd_hi[47:40])
   );
   scicfg_dbuf #(.W(`SCICFG_W_WIDE), .RST(`SCICFG_RST_MON)) u_mcb (
      .clk_in       (CLK_SYS_IN),
      .rst_n_in     (RESETN_IN),
      .wr_lo_in     (wr_lo[6]),
      .wr_hi_in     (wr_hi[6]),
      .wdata_in     (REG_WDATA_IN),
      .commit_in    (COMMIT_PULSE_OUT),
      .rb_shadow_in (readback_copy_select_q),
      .active_out   (MONITOR_COUNT_B_OUT),
      .rd_lo_out    (rd_lo[55:48]),
      .rd_hi_out    (rd_hi[55:48])
   );

   // Commit strobe: one cycle, so the bit clears itself by hardware
   always @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN)
         COMMIT_PULSE_OUT <= 1'b0;
      else
         COMMIT_PULSE_OUT <= wr_ctrl &&
                             REG_WDATA_IN[`SCICFG_BIT_COMMIT];
   end

   // Read-back select lives beside the commit bit
   always @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN)
         readback_copy_select_q <= `SCICFG_RST_RB_SEL;
      else if (wr_ctrl)
         readback_copy_select_q <= REG_WDATA_IN[`SCICFG_BIT_RB_SEL];
   end

   // Pad level selects; pad cells sit outside this bank
   always @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT    <=
            `SCICFG_RST_FBLOCK_LVL;
         IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT <= `SCICFG_RST_IRQ_LVL;
         SERIAL_IO_LEVEL_SELECT_OUT            <=
            `SCICFG_RST_SERIAL_LVL;
      end else if (wr_lvl) begin
         FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT    <=
            REG_WDATA_IN[`SCICFG_BIT_FBLOCK_LVL];
         IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT <=
            REG_WDATA_IN[`SCICFG_BIT_IRQ_LVL];
         SERIAL_IO_LEVEL_SELECT_OUT            <=
            REG_WDATA_IN[`SCICFG_BIT_SERIAL_LVL];
      end
   end

   // Read mux; unmapped addresses return zero
   always @* begin
      rdata_d = `SCICFG_BYTE_ZERO;
      case (REG_ADDR_IN)
         `SCICFG_ADDR_MAKER_LO: rdata_d = maker_code[7:0];
         `SCICFG_ADDR_MAKER_HI: rdata_d = maker_code[15:8];
         `SCICFG_ADDR_LVL: begin
            rdata_d[`SCICFG_BIT_FBLOCK_LVL] =
               FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT;
            rdata_d[`SCICFG_BIT_IRQ_LVL]    =
               IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT;
            rdata_d[`SCICFG_BIT_SERIAL_LVL] = SERIAL_IO_LEVEL_SELECT_OUT;
         end
         `SCICFG_ADDR_CTRL: begin
            rdata_d[`SCICFG_BIT_COMMIT] = COMMIT_PULSE_OUT;
            rdata_d[`SCICFG_BIT_RB_SEL] = readback_copy_select_q;
         end
         `SCICFG_ADDR_PVA_LO: rdata_d = rd_lo[7:0];
         `SCICFG_ADDR_PVA_HI: rdata_d = rd_hi[7:0];
         `SCICFG_ADDR_PVB_LO: rdata_d = rd_lo[15:8];
         `SCICFG_ADDR_PVB_HI: rdata_d = rd_hi[15:8];
         `SCICFG_ADDR_OFB_LO: rdata_d = rd_lo[23:16];
         `SCICFG_ADDR_OFB_HI: rdata_d = rd_hi[23:16];
         `SCICFG_ADDR_LPW_LO: rdata_d = rd_lo[31:24];
         `SCICFG_ADDR_LPW_HI: rdata_d = rd_hi[31:24];
         `SCICFG_ADDR_SFB_LO: rdata_d = rd_lo[39:32];
         `SCICFG_ADDR_SFB_HI: rdata_d = rd_hi[39:32];
         `SCICFG_ADDR_MCA_LO: rdata_d = rd_lo[47:40];
         `SCICFG_ADDR_MCA_HI: rdata_d = rd_hi[47:40];
         `SCICFG_ADDR_MCB_LO: rdata_d = rd_lo[55:48];
         `SCICFG_ADDR_MCB_HI: rdata_d = rd_hi[55:48];
         default: rdata_d = `SCICFG_BYTE_ZERO;
      endcase
   end

   // Registered read answer, one cycle after the request
   always @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         REG_RDATA_OUT  <= `SCICFG_BYTE_ZERO;
         REG_RVALID_OUT <= 1'b0;
      end else begin
         REG_RVALID_OUT <= REG_RD_IN;
         if (REG_RD_IN)
            REG_RDATA_OUT <= rdata_d;
      end
   end

endmodule

/* scicfg_bank_props.sv */
// Port-level assertions for the config bank
`timescale 1ns/1ps
`include "scicfg_defs.vh"
module scicfg_bank_props (
   input wire        CLK_SYS_IN,
   input wire        RESETN_IN,
   input wire        REG_WR_IN,
   input wire        REG_RD_IN,
   input wire [7:0]  REG_ADDR_IN,
   input wire [7:0]  REG_WDATA_IN,
   input wire [7:0]  REG_RDATA_OUT,
   input wire        REG_RVALID_OUT,
   input wire        COMMIT_PULSE_OUT,
   input wire        FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT,
   input wire        IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT,
   input wire        SERIAL_IO_LEVEL_SELECT_OUT,
   input wire [14:0] INPUT_PREDIV_A_OUT,
   input wire [14:0] INPUT_PREDIV_B_OUT,
   input wire [14:0] OSC_FEEDBACK_DIV_OUT,
   input wire [14:0] LOCK_PHASE_WINDOW_OUT,
   input wire [8:0]  SYNTH_FEEDBACK_DIV_OUT,
   input wire [14:0] MONITOR_COUNT_A_OUT,
   input wire [14:0] MONITOR_COUNT_B_OUT
);
   localparam [15:0] MK = `SCICFG_MAKER_CODE;
   // Decoded requests
   wire lvl_wr = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_LVL);
   wire cmt_wr = REG_WR_IN && (REG_ADDR_IN == `SCICFG_ADDR_CTRL)
                 && REG_WDATA_IN[`SCICFG_BIT_COMMIT];
   wire [98:0] acts = {INPUT_PREDIV_A_OUT, INPUT_PREDIV_B_OUT,
      OSC_FEEDBACK_DIV_OUT, LOCK_PHASE_WINDOW_OUT, SYNTH_FEEDBACK_DIV_OUT,
      MONITOR_COUNT_A_OUT, MONITOR_COUNT_B_OUT};
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESETN_IN);
   // Past-reset guards: release of reset would look like a change
   a_commit_pulse:
      assert property (cmt_wr |=> COMMIT_PULSE_OUT)
      else $error("commit pulse missing");
   a_commit_cause:
      assert property (COMMIT_PULSE_OUT |-> $past(cmt_wr))
      else $error("commit pulse without commit write");
   a_active_hold:
      assert property ($past(RESETN_IN) && $changed(acts)
                       |-> $past(COMMIT_PULSE_OUT))
      else $error("active divider changed without commit");
   a_maker_low:
      assert property (REG_RD_IN && REG_ADDR_IN == `SCICFG_ADDR_MAKER_LO
                       |=> REG_RVALID_OUT && REG_RDATA_OUT == MK[7:0])
      else $error("maker code low byte wrong");
   a_maker_high:
      assert property (REG_RD_IN && REG_ADDR_IN == `SCICFG_ADDR_MAKER_HI
                       |=> REG_RVALID_OUT && REG_RDATA_OUT == MK[15:8])
      else $error("maker code high byte wrong");
   a_fb_level:
      assert property (lvl_wr |=> FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT
                       == $past(REG_WDATA_IN[`SCICFG_BIT_FBLOCK_LVL]))
      else $error("feedback lock level not written");
   a_irq_level:
      assert property ($past(RESETN_IN)
         && $changed(IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT) |-> $past(lvl_wr))
      else $error("irq level changed without write");
   a_serial_level:
      assert property (lvl_wr |=> SERIAL_IO_LEVEL_SELECT_OUT
                       == $past(REG_WDATA_IN[`SCICFG_BIT_SERIAL_LVL]))
      else $error("serial level not written");
   c_commit: cover property (COMMIT_PULSE_OUT);
   c_read: cover property (REG_RVALID_OUT);
   c_level: cover property (lvl_wr);
endmodule

/* scicfg_host_model.sv */
// Host model driving the byte register port of the config bank
`timescale 1ns/1ps
module scicfg_host_model (
   input  wire       clk_in,
   input  wire [7:0] rdata_in,
   input  wire       rvalid_in,
   output reg        wr_out,
   output reg        rd_out,
   output reg  [7:0] addr_out,
   output reg  [7:0] wdata_out
);
   // Idle bus carries junk so stale values never pass
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'hFF;
      wdata_out = 8'hFF;
   end
   // One byte write, held across one rising edge
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk_in);
         wr_out = 1'b1;
         addr_out = a;
         wdata_out = d;
         @(negedge clk_in);
         wr_out = 1'b0;
         addr_out = ~a;
         wdata_out = ~d;
      end
   endtask
   // One byte read; a missing valid strobe gives unknown data
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(negedge clk_in);
         rd_out = 1'b1;
         addr_out = a;
         @(negedge clk_in);
         rd_out = 1'b0;
         addr_out = ~a;
         d = rvalid_in ? rdata_in : 8'hXX;
      end
   endtask
endmodule

/* shadow_commit_and_io_level_config_test.sv */
// Self-checking bench for the config bank
`timescale 1ns/1ps
`include "scicfg_defs.vh"
module shadow_commit_and_io_level_config_test;
   reg         CLK_SYS_IN;
   reg         RESETN_IN;
   wire        REG_WR_IN, REG_RD_IN, REG_RVALID_OUT, COMMIT_PULSE_OUT;
   wire [7:0]  REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT;
   wire        FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT;
   wire        IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT;
   wire        SERIAL_IO_LEVEL_SELECT_OUT;
   wire [14:0] INPUT_PREDIV_A_OUT, INPUT_PREDIV_B_OUT, OSC_FEEDBACK_DIV_OUT;
   wire [14:0] LOCK_PHASE_WINDOW_OUT, MONITOR_COUNT_A_OUT, MONITOR_COUNT_B_OUT;
   wire [8:0]  SYNTH_FEEDBACK_DIV_OUT;
   localparam [15:0] MK = `SCICFG_MAKER_CODE;
   localparam [104:0] ACT_RST = {`SCICFG_RST_MON, `SCICFG_RST_MON, 6'h00,
      `SCICFG_RST_SFB, `SCICFG_RST_LPW, `SCICFG_RST_OFB, `SCICFG_RST_PREDIV,
      `SCICFG_RST_PREDIV};
   integer     num_errors, n_checks, cyc, i;
   reg [7:0]   rv;
   reg [104:0] ev;
   // Field k at 15-bit slice k, synth feedback zero-padded
   wire [104:0] acts = {MONITOR_COUNT_B_OUT, MONITOR_COUNT_A_OUT, 6'h00,
      SYNTH_FEEDBACK_DIV_OUT, LOCK_PHASE_WINDOW_OUT, OSC_FEEDBACK_DIV_OUT,
      INPUT_PREDIV_B_OUT, INPUT_PREDIV_A_OUT};
   wire [2:0] lvls = {FEEDBACK_LOCK_PIN_LEVEL_SELECT_OUT,
      IRQ_AND_OSC_LOCK_PIN_LEVEL_SELECT_OUT, SERIAL_IO_LEVEL_SELECT_OUT};

   scicfg_bank i_dut (.*);
   scicfg_host_model i_host (.clk_in(CLK_SYS_IN), .rdata_in(REG_RDATA_OUT),
      .rvalid_in(REG_RVALID_OUT), .wr_out(REG_WR_IN), .rd_out(REG_RD_IN),
      .addr_out(REG_ADDR_IN), .wdata_out(REG_WDATA_IN));

   function [7:0] lo_a(input [2:0] k);
      lo_a = (k < 3'd4) ? 8'h10 + {4'h0, k, 1'b0} :
             (k == 3'd4) ? 8'h1A : 8'h26 + {4'h0, k, 1'b0};
   endfunction
   // Reserved bit 7 of the high byte is always set to test dropping
   function [7:0] hi_v(input [2:0] k);
      hi_v = 8'hF1 + {5'h00, k};
   endfunction
   function [14:0] ex_act(input [2:0] k);
      reg [7:0] hb;
      begin
         hb = hi_v(k);
         ex_act = (k == 3'd4) ? {6'h00, hb[0], 5'h08, k} : {hb[6:0], 5'h08, k};
      end
   endfunction
   task chk(input [8*8:1] nm, input [104:0] s, input [104:0] e);
      begin
         n_checks = n_checks + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, s);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial begin
      CLK_SYS_IN = 1'b0;
      forever #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
   end
   // Hang guard, far above the roughly 85 cycles needed
   always @(posedge CLK_SYS_IN) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end

   initial begin
      num_errors = 0;
      n_checks = 0;
      cyc = 0;
      ev = 105'h0;
      RESETN_IN = 1'b0;
      repeat (4) @(posedge CLK_SYS_IN);
      @(negedge CLK_SYS_IN);
      RESETN_IN = 1'b1;
      chk("lvl_rst", lvls, 3'b010);
      chk("act_rst", acts, ACT_RST);
      i_host.rd(`SCICFG_ADDR_MAKER_LO, rv);
      chk("mk_lo", rv, MK[7:0]);
      i_host.wr(`SCICFG_ADDR_MAKER_HI, 8'h00);
      i_host.rd(`SCICFG_ADDR_MAKER_HI, rv);
      chk("mk_hi", rv, MK[15:8]);
      // Every select moved off its default, then back
      i_host.wr(`SCICFG_ADDR_LVL, 8'h05);
      chk("lvl_set", lvls, 3'b101);
      i_host.rd(`SCICFG_ADDR_LVL, rv);
      chk("lvl_rd", rv, 8'h05);
      i_host.wr(`SCICFG_ADDR_LVL, 8'h02);
      chk("lvl_back", lvls, 3'b010);
      // High byte first: halves are independent
      for (i = 0; i < 7; i = i + 1) begin
         i_host.wr(lo_a(i[2:0]) + 8'h01, hi_v(i[2:0]));
         i_host.wr(lo_a(i[2:0]), {5'h08, i[2:0]});
         ev[i*15 +: 15] = ex_act(i[2:0]);
      end
      i_host.rd(`SCICFG_ADDR_PVA_LO, rv);
      chk("rb_act", rv, ACT_RST[7:0]);
      i_host.wr(`SCICFG_ADDR_CTRL, 8'h02);
      chk("no_cmt", COMMIT_PULSE_OUT, 1'b0);
      chk("act_hold", acts, ACT_RST);
      for (i = 0; i < 7; i = i + 1) begin
         i_host.rd(lo_a(i[2:0]), rv);
         chk("rb_lo", rv, ev[i*15 +: 8]);
         i_host.rd(lo_a(i[2:0]) + 8'h01, rv);
         chk("rb_hi", rv, {1'b0, ev[i*15+8 +: 7]});
      end
      i_host.wr(`SCICFG_ADDR_CTRL, 8'h03);
      chk("cmt", COMMIT_PULSE_OUT, 1'b1);
      i_host.rd(`SCICFG_ADDR_CTRL, rv);
      chk("cmt_clr", rv, 8'h02);
      chk("act_cmt", acts, ev);
      // Back to active read-back: committed value must show there
      i_host.wr(`SCICFG_ADDR_CTRL, 8'h00);
      i_host.rd(`SCICFG_ADDR_MCB_HI, rv);
      chk("rb_new", rv, {1'b0, ev[98 +: 7]});
      report_and_stop;
   end
endmodule

bind scicfg_bank scicfg_bank_props i_props (.*);
